/* rbm_top.sv */
/*
 * Byte-masked synchronous RAM with two ports, per-port address hold,
 * combined 16-lane mask in the widest mode and two-memory packing.
 * Assumes one clock; user logic on that clock drives every input.
 */
`timescale 1ns/1ps
module rbm_top #(
   parameter int AW = rbm_pkg::RBM_ADDR_W
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire rbm_pkg::rbm_width_e cfg_width,
   input wire logic cfg_pack,
   input wire logic we_a,
   input wire logic [rbm_pkg::RBM_PORT_LANES-1:0] mask_a =
      rbm_pkg::RBM_MASK_DEF,
   input wire logic hold_a = rbm_pkg::RBM_HOLD_DEF,
   input wire logic [AW-1:0] addr_a,
   input wire logic [rbm_pkg::RBM_PORT_W-1:0] wdata_a,
   input wire logic ce_a = rbm_pkg::RBM_CE_DEF,
   input wire logic clr_a = rbm_pkg::RBM_CLR_DEF,
   output logic [rbm_pkg::RBM_PORT_W-1:0] rdata_a_reg,
   input wire logic we_b,
   input wire logic [rbm_pkg::RBM_PORT_LANES-1:0] mask_b =
      rbm_pkg::RBM_MASK_DEF,
   input wire logic hold_b = rbm_pkg::RBM_HOLD_DEF,
   input wire logic [AW-1:0] addr_b,
   input wire logic [rbm_pkg::RBM_PORT_W-1:0] wdata_b,
   input wire logic ce_b = rbm_pkg::RBM_CE_DEF,
   input wire logic clr_b = rbm_pkg::RBM_CLR_DEF,
   output logic [rbm_pkg::RBM_PORT_W-1:0] rdata_b_reg
);
   import rbm_pkg::*;

   localparam int DEPTH = 1 << AW;

   // ***************************************************************
   // Lane helpers
   // ***************************************************************
   function automatic logic [8:0] lane_in(input logic [71:0] d,
                                          input int n,
                                          input logic par);
      if (par) begin
         lane_in = d[9*n +: 9];
      end else begin
         lane_in = {1'b0, d[8*n +: 8]};
      end
   endfunction

   function automatic logic [71:0] assemble(input logic [7:0][8:0] v,
                                            input int nl,
                                            input logic par);
      assemble = '0;
      for (int n = 0; n < RBM_PORT_LANES; n++) begin
         if (n < nl) begin
            if (par) begin
               assemble[9*n +: 9] = v[n];
            end else begin
               assemble[8*n +: 8] = v[n][7:0];
            end
         end
      end
   endfunction

   // ***************************************************************
   // Port input stages
   // ***************************************************************
   logic we_a_q;
   logic we_b_q;
   logic [7:0] mask_a_q;
   logic [7:0] mask_b_q;
   logic [AW-1:0] addr_a_q;
   logic [AW-1:0] addr_b_q;
   logic [71:0] wdata_a_q;
   logic [71:0] wdata_b_q;

   // Separate instances give each port its own hold
   rbm_port #(.AW(AW)) u_port_a (
      .clk(clk),
      .rst_n(rst_n),
      .we(we_a),
      .mask(mask_a),
      .hold(hold_a),
      .addr(addr_a),
      .wdata(wdata_a),
      .we_q(we_a_q),
      .mask_q(mask_a_q),
      .addr_q(addr_a_q),
      .wdata_q(wdata_a_q)
   );

   rbm_port #(.AW(AW)) u_port_b (
      .clk(clk),
      .rst_n(rst_n),
      .we(we_b),
      .mask(mask_b),
      .hold(hold_b),
      .addr(addr_b),
      .wdata(wdata_b),
      .we_q(we_b_q),
      .mask_q(mask_b_q),
      .addr_q(addr_b_q),
      .wdata_q(wdata_b_q)
   );

   // ***************************************************************
   // Mode decode and rows
   // ***************************************************************
   int lanes;
   logic wide;
   logic par;
   logic [AW-1:0] row_a;
   logic [AW-1:0] row_b;

   assign lanes = rbm_lanes(cfg_width);
   assign wide = (lanes == RBM_LANES);
   assign par = rbm_parity(cfg_width);

   // Packing splits the block by the top row bit, one half per port
   assign row_a = cfg_pack ? {1'b0, addr_a_q[AW-2:0]} : addr_a_q;
   assign row_b = cfg_pack ? {1'b1, addr_b_q[AW-2:0]} : addr_b_q;

   // ***************************************************************
   // Lane write enables and write-through view
   // ***************************************************************
   logic [15:0][8:0] mem [DEPTH];
   logic [15:0] wen_a;
   logic [15:0] wen_b;
   logic [15:0][8:0] din_a;
   logic [15:0][8:0] din_b;
   logic [15:0][8:0] look_a;
   logic [15:0][8:0] look_b;

   for (genvar l = 0; l < RBM_LANES; l++) begin : g_lane
      if (l < RBM_PORT_LANES) begin : g_lo
         // Strobe and mask bit together, only lanes that exist
         assign wen_a[l] = we_a_q && mask_a_q[l] &&
                           (wide || l < lanes);
         assign din_a[l] = lane_in(wdata_a_q, l, par);
         assign wen_b[l] = we_b_q && mask_b_q[l] && !wide &&
                           l < lanes;
         assign din_b[l] = lane_in(wdata_b_q, l, par);
      end else begin : g_hi
         // Upper eight lanes come from port B in the widest mode
         assign wen_a[l] = we_a_q && mask_b_q[l-8] && wide;
         assign din_a[l] = lane_in(wdata_b_q, l - 8, par);
         assign wen_b[l] = 1'b0;
         assign din_b[l] = '0;
      end
      // Written lanes flow through; unwritten show stored data
      assign look_a[l] = wen_a[l] ? din_a[l] : mem[row_a][l];
      assign look_b[l] = wen_b[l] ? din_b[l] : mem[row_b][l];
   end

   // ***************************************************************
   // Storage
   // ***************************************************************
   // Only enabled lanes are touched, so the rest keep their data
   always_ff @(posedge clk) begin
      for (int l = 0; l < RBM_LANES; l++) begin
         if (wen_a[l]) begin
            mem[row_a][l] <= din_a[l];
         end
         if (wen_b[l]) begin
            mem[row_b][l] <= din_b[l];
         end
      end
   end

   // ***************************************************************
   // Read registers
   // ***************************************************************
   logic [71:0] rdata_a_next;
   logic [71:0] rdata_b_next;

   assign rdata_a_next = assemble(look_a[7:0], lanes, par);
   assign rdata_b_next = wide ? assemble(look_a[15:8], lanes, par)
                              : assemble(look_b[7:0], lanes, par);

   // Enable and clear are per port, so packed halves stay independent
   always_ff @(posedge clk) begin
      if (!rst_n || clr_a) begin
         rdata_a_reg <= RBM_RDATA_RST;
      end else if (ce_a) begin
         rdata_a_reg <= rdata_a_next;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n || clr_b) begin
         rdata_b_reg <= RBM_RDATA_RST;
      end else if (ce_b) begin
         rdata_b_reg <= rdata_b_next;
      end
   end

   // ***************************************************************
   // Checks
   // ***************************************************************
   logic [8:0] old_a0;
   logic [8:0] din_b0;
   assign old_a0 = mem[row_a][0];
   assign din_b0 = din_b[0];

   sequence s_a_live;
      ce_a && !clr_a;
   endsequence
   sequence s_b_live;
      ce_b && !clr_b;
   endsequence

   wr_through_a: assert property (
      @(posedge clk) disable iff (!rst_n)
      !wide && !par && we_a_q && mask_a_q[0] ##0 s_a_live
      |=> rdata_a_reg[7:0] == $past(wdata_a_q[7:0]))
      else $error("new data not shown on written lane");

   parity_lane_a: assert property (
      @(posedge clk) disable iff (!rst_n)
      cfg_width == RBM_W36 && we_a_q && mask_a_q[3] ##0 s_a_live
      |=> rdata_a_reg[35:27] == $past(wdata_a_q[35:27]))
      else $error("nine-bit lane 3 misplaced");

   wide_merge_a: assert property (
      @(posedge clk) disable iff (!rst_n)
      cfg_width == RBM_W128 && we_a_q && mask_b_q[0] ##0 s_b_live
      |=> rdata_b_reg[7:0] == $past(wdata_b_q[7:0]))
      else $error("lane 8 not written from port B mask");

   top_lane_a: assert property (
      @(posedge clk) disable iff (!rst_n)
      cfg_width == RBM_W144 && we_a_q && mask_b_q[7] ##0 s_b_live
      |=> rdata_b_reg[71:63] == $past(wdata_b_q[71:63]))
      else $error("top lane of wide word misplaced");

   masked_keep_a: assert property (
      @(posedge clk) disable iff (!rst_n)
      we_a_q && !wen_a[0] && !wen_b[0]
      |=> mem[$past(row_a)][0] == $past(old_a0))
      else $error("masked lane changed during write");

   pack_half_a: assert property (
      @(posedge clk) disable iff (!rst_n)
      cfg_pack && wen_b[0] && !(wen_a[0] && row_a == row_b)
      |=> $past(row_b[AW-1]) && mem[$past(row_b)][0] == $past(din_b0))
      else $error("packed port B left its half");

   clr_port_a: assert property (
      @(posedge clk) disable iff (!rst_n)
      clr_a && !clr_b && ce_b |=> rdata_a_reg == RBM_RDATA_RST &&
      rdata_b_reg == $past(rdata_b_next))
      else $error("clear leaked between ports");

   no_strobe_a: assert property (
      @(posedge clk) disable iff (!rst_n)
      !we_a_q && !we_b_q |-> wen_a == '0 && wen_b == '0)
      else $error("lane written without strobe");

   rd_enable_a: assert property (
      @(posedge clk) disable iff (!rst_n)
      !ce_b && !clr_b |=> $stable(rdata_b_reg))
      else $error("read register moved with enable low");

   lane_exact_a: assert property (
      @(posedge clk) disable iff (!rst_n)
      we_a_q && lanes == RBM_PORT_LANES |-> wen_a[7:0] == mask_a_q)
      else $error("written lanes differ from mask");

   narrow_zero_a: assert property (
      @(posedge clk) disable iff (!rst_n)
      !par |=> rdata_a_reg[71:64] == 8'h00)
      else $error("bits above the word not zero");

   wide_b_idle_a: assert property (
      @(posedge clk) disable iff (!rst_n)
      wide |-> wen_b == 16'h0000)
      else $error("port B wrote on its own in the widest mode");

   wr_through_b_a: assert property (
      @(posedge clk) disable iff (!rst_n)
      !wide && we_b_q && mask_b_q[0] ##0 s_b_live
      |=> rdata_b_reg[7:0] == $past(din_b0[7:0]))
      else $error("port B written lane not shown");

endmodule

/* rbm_pkg.sv */
/*
 * Shared constants, width modes and lane helpers for the byte-masked RAM
 * block with per-port address hold.
 * Assumes one clock domain; all users import the whole package.
 */
package rbm_pkg;

   // ***************************************************************
   // Geometry
   // ***************************************************************
   localparam int RBM_LANES = 16;
   localparam int RBM_LANE_W = 9;
   localparam int RBM_PORT_W = 72;
   localparam int RBM_PORT_LANES = 8;
   localparam int RBM_ADDR_W = 6;

   // ***************************************************************
   // Reset and tie-off values
   // ***************************************************************
   localparam logic [7:0] RBM_MASK_DEF = 8'hFF;
   localparam logic RBM_HOLD_DEF = 1'b0;
   localparam logic RBM_CE_DEF = 1'b1;
   localparam logic RBM_CLR_DEF = 1'b0;
   localparam logic [71:0] RBM_RDATA_RST = 72'h00_0000_0000_0000_0000;

   typedef enum logic [3:0] {
      RBM_W8, RBM_W9, RBM_W16, RBM_W18, RBM_W32,
      RBM_W36, RBM_W64, RBM_W72, RBM_W128, RBM_W144
   } rbm_width_e;

   // Lanes used by one word at the given width
   function automatic int rbm_lanes(input rbm_width_e m);
      case (m)
         RBM_W8, RBM_W9: rbm_lanes = 1;
         RBM_W16, RBM_W18: rbm_lanes = 2;
         RBM_W32, RBM_W36: rbm_lanes = 4;
         RBM_W64, RBM_W72: rbm_lanes = 8;
         default: rbm_lanes = 16;
      endcase
   endfunction

   // Nine-bit lanes for the parity widths
   function automatic logic rbm_parity(input rbm_width_e m);
      case (m)
         RBM_W9, RBM_W18, RBM_W36, RBM_W72, RBM_W144: rbm_parity = 1'b1;
         default: rbm_parity = 1'b0;
      endcase
   endfunction

endpackage

/* rbm_port.sv */
/*
 * Input register stage of one RAM port: address register with hold
 * multiplexer, mask, data and write strobe registers.
 * Assumes inputs come from logic on the same clock.
 */
`timescale 1ns/1ps
module rbm_port #(
   parameter int AW = rbm_pkg::RBM_ADDR_W
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic we,
   input wire logic [rbm_pkg::RBM_PORT_LANES-1:0] mask,
   input wire logic hold,
   input wire logic [AW-1:0] addr,
   input wire logic [rbm_pkg::RBM_PORT_W-1:0] wdata,
   output logic we_q,
   output logic [rbm_pkg::RBM_PORT_LANES-1:0] mask_q,
   output logic [AW-1:0] addr_q,
   output logic [rbm_pkg::RBM_PORT_W-1:0] wdata_q
);
   import rbm_pkg::*;

   // ***************************************************************
   // Address hold
   // ***************************************************************
   logic [AW-1:0] addr_next;

   // Register feeds itself back while held
   assign addr_next = hold ? addr_q : addr;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         addr_q <= '0;
         we_q <= 1'b0;
      end else begin
         addr_q <= addr_next;
         we_q <= we;
      end
   end

   // No clear on mask and data: they change only on a clock edge
   always_ff @(posedge clk) begin
      mask_q <= mask;
      wdata_q <= wdata;
   end

   // ***************************************************************
   // Checks
   // ***************************************************************
   property p_hold;
      @(posedge clk) disable iff (!rst_n)
      hold |=> addr_q == $past(addr_q);
   endproperty
   addr_hold_a: assert property (p_hold)
      else $error("address changed while held");

   addr_load_a: assert property (
      @(posedge clk) disable iff (!rst_n)
      !hold |=> addr_q == $past(addr))
      else $error("address not loaded while hold low");

   sequence s_mask_taken;
      ##1 mask_q == $past(mask);
   endsequence
   mask_capture_a: assert property (
      @(posedge clk) disable iff (!rst_n) 1'b1 |-> s_mask_taken)
      else $error("mask register missed its edge");

endmodule

/* rbm_user_model.sv */
/*
 * User-logic model driving one RAM port.
 * Assumes the RAM clock is the only clock it sees.
 */
`timescale 1ns/1ps
module rbm_user_model #(
   parameter int AW = 6
) (
   input wire logic clk,
   output logic we,
   output logic [7:0] mask,
   output logic hold,
   output logic [AW-1:0] addr,
   output logic [71:0] wdata
);
   initial begin
      we = 1'b0;
      mask = 8'hFF;
      hold = 1'b0;
      addr = '0;
      wdata = '0;
   end

   // One request per edge; caller varies idle data
   task automatic drive(input logic w, input logic [7:0] m,
      input logic h, input int a, input logic [71:0] d);
      @(posedge clk);
      we <= w;
      mask <= m;
      hold <= h;
      addr <= a[AW-1:0];
      wdata <= d;
   endtask
endmodule

/* tb_ram_byte_mask_addr_hold.sv */
/*
 * Self-checking bench for the byte-masked RAM with address hold.
 * Assumes one 100 MHz clock and two user-port models.
 */
`timescale 1ns/1ps
module tb_ram_byte_mask_addr_hold;
   import rbm_pkg::*;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   rbm_width_e cfg_width = RBM_W72;
   logic cfg_pack = 1'b0;
   logic ce_a = 1'b1;
   logic ce_b = 1'b1;
   logic clr_a = 1'b0;
   logic clr_b = 1'b0;
   logic we_a, we_b, hold_a, hold_b;
   logic [7:0] mask_a, mask_b;
   logic [5:0] addr_a, addr_b;
   logic [71:0] wdata_a, wdata_b, rd_a, rd_b;
   int err_count = 0;
   int num_checks = 0;

   always #5 clk = ~clk;

   rbm_user_model #(.AW(6)) pa (.clk(clk), .we(we_a), .mask(mask_a),
      .hold(hold_a), .addr(addr_a), .wdata(wdata_a));
   rbm_user_model #(.AW(6)) pb (.clk(clk), .we(we_b), .mask(mask_b),
      .hold(hold_b), .addr(addr_b), .wdata(wdata_b));

   rbm_top #(.AW(6)) DUT (.clk(clk), .rst_n(rst_n),
      .cfg_width(cfg_width), .cfg_pack(cfg_pack),
      .we_a(we_a), .mask_a(mask_a), .hold_a(hold_a), .addr_a(addr_a),
      .wdata_a(wdata_a), .ce_a(ce_a), .clr_a(clr_a), .rdata_a_reg(rd_a),
      .we_b(we_b), .mask_b(mask_b), .hold_b(hold_b), .addr_b(addr_b),
      .wdata_b(wdata_b), .ce_b(ce_b), .clr_b(clr_b), .rdata_b_reg(rd_b));

   // *****
   // Helpers
   // *****
   task automatic chk(input string nm, input logic [71:0] e,
      input logic [71:0] g);
      num_checks++;
      if (g !== e) begin
         err_count++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask

   // Lanes past the width read as zero
   function automatic logic [71:0] mrg(input logic [71:0] o,
      input logic [71:0] n, input logic [7:0] m, input int nl,
      input int lw);
      for (int i = 0; i < 72; i++) begin
         mrg[i] = (i / lw >= nl) ? 1'b0 : (m[i / lw] ? n[i] : o[i]);
      end
   endfunction

   task automatic tick;
      @(posedge clk);
      #1;
   endtask

   task automatic setw(input int w, input logic p);
      @(posedge clk);
      cfg_width <= rbm_width_e'(w);
      cfg_pack <= p;
   endtask

   task automatic complete_run;
      $display("checks %0d errors %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // *****
   // Scenarios
   // *****
   task automatic t_mask(input int w);
      int nl;
      int lw;
      logic [71:0] d1;
      logic [71:0] d2;
      logic [7:0] m;
      nl = 1 << (w / 2);
      lw = (w % 2) ? 9 : 8;
      d1 = {9{8'hC3 ^ 8'(w)}};
      d2 = {9{8'h5A + 8'(w)}};
      m = 8'hA5 ^ 8'(w << 2);
      setw(w, 1'b0);
      pa.drive(1'b1, 8'hFF, 1'b0, w, d1);
      pa.drive(1'b1, m, 1'b0, w, d2);
      // Strobe low with fresh data must store nothing
      pa.drive(1'b0, 8'hFF, 1'b0, w, ~d2);
      tick;
      chk("write view", mrg(d1, d2, m, nl, lw), rd_a);
      tick;
      chk("stored", mrg(d1, d2, m, nl, lw), rd_a);
   endtask

   task automatic t_wide(input rbm_width_e w);
      int lw;
      lw = (w == RBM_W144) ? 9 : 8;
      setw(w, 1'b0);
      fork
         pa.drive(1'b1, 8'hFF, 1'b0, 9, {8{9'h1A5}});
         pb.drive(1'b0, 8'hFF, 1'b0, 0, {8{9'h0F0}});
      join
      fork
         pa.drive(1'b1, 8'h3C, 1'b0, 9, {8{9'h15A}});
         pb.drive(1'b0, 8'hC3, 1'b0, 0, {8{9'h10F}});
      join
      pa.drive(1'b0, 8'hFF, 1'b0, 9, '1);
      tick;
      tick;
      chk("wide low", mrg({8{9'h1A5}}, {8{9'h15A}}, 8'h3C, 8, lw),
         rd_a);
      chk("wide high", mrg({8{9'h0F0}}, {8{9'h10F}}, 8'hC3, 8, lw),
         rd_b);
   endtask

   task automatic t_hold;
      setw(RBM_W72, 1'b0);
      pa.drive(1'b1, 8'hFF, 1'b0, 3, {9{8'h33}});
      pa.drive(1'b1, 8'hFF, 1'b0, 4, {9{8'h44}});
      pa.drive(1'b0, 8'hFF, 1'b0, 3, '1);
      fork
         pa.drive(1'b0, 8'hFF, 1'b1, 4, '0);
         pb.drive(1'b0, 8'hFF, 1'b0, 4, '0);
      join
      pa.drive(1'b0, 8'hFF, 1'b1, 4, '1);
      tick;
      chk("held addr", {9{8'h33}}, rd_a);
      chk("other port", {9{8'h44}}, rd_b);
      pa.drive(1'b0, 8'hFF, 1'b0, 4, '0);
      tick;
      chk("held addr", {9{8'h33}}, rd_a);
      tick;
      chk("released addr", {9{8'h44}}, rd_a);
   endtask

   task automatic t_pack;
      setw(RBM_W36, 1'b1);
      fork
         pa.drive(1'b1, 8'hFF, 1'b0, 2, {9{8'h66}});
         pb.drive(1'b1, 8'hFF, 1'b0, 2, {9{8'h99}});
      join
      fork
         pa.drive(1'b0, 8'hFF, 1'b0, 2, '1);
         pb.drive(1'b0, 8'hFF, 1'b0, 2, '1);
      join
      tick;
      tick;
      chk("pack a", mrg('0, {9{8'h66}}, 8'hFF, 4, 9), rd_a);
      chk("pack b", mrg('0, {9{8'h99}}, 8'hFF, 4, 9), rd_b);
      @(posedge clk);
      clr_a <= 1'b1;
      @(posedge clk);
      clr_a <= 1'b0;
      ce_b <= 1'b0;
      #1;
      chk("cleared a", '0, rd_a);
      chk("kept b", mrg('0, {9{8'h99}}, 8'hFF, 4, 9), rd_b);
      // Enable low: a fresh write must not reach the read register
      pb.drive(1'b1, 8'hFF, 1'b0, 2, {9{8'h77}});
      pb.drive(1'b0, 8'hFF, 1'b0, 2, '1);
      tick;
      chk("enable low b", mrg('0, {9{8'h99}}, 8'hFF, 4, 9), rd_b);
      @(posedge clk);
      ce_b <= 1'b1;
      tick;
      chk("enable high b", mrg('0, {9{8'h77}}, 8'hFF, 4, 9), rd_b);
   endtask

   initial begin
      // Memory is not cleared, so look at the read registers in reset
      repeat (9) @(posedge clk);
      #1;
      chk("reset read", RBM_RDATA_RST, rd_a);
      chk("reset read b", RBM_RDATA_RST, rd_b);
      @(posedge clk);
      rst_n <= 1'b1;
      for (int w = 0; w < 8; w++) begin
         t_mask(w);
      end
      t_wide(RBM_W128);
      t_wide(RBM_W144);
      t_hold;
      t_pack;
      complete_run;
   end

   // Whole run is about ninety cycles
   initial begin
      #20000;
      err_count++;
      complete_run;
   end
endmodule
